// File: core/serial_rx_pkg.sv
package serial_rx_pkg;
  // character size codes
  localparam logic [2:0] CS_9L      = 3'h6;
  localparam logic [2:0] CS_9H      = 3'h7;
  // communication modes
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_SPI   = 2'h3;
  // asynchronous reception mode with eight samples per bit
  localparam logic [1:0] RXM_DOUBLE = 2'h1;
  // parity modes, low bit set means odd
  localparam logic [1:0] PAR_EVEN   = 2'h2;
  localparam logic [1:0] PAR_ODD    = 2'h3;
  // samples per bit
  localparam logic [4:0] OS_NORMAL  = 5'h10;
  localparam logic [4:0] OS_DOUBLE  = 5'h08;
  localparam logic [4:0] VOTE_SPAN  = 5'h02;
  localparam logic [4:0] OS_FIRST   = 5'h01;
  // frame sizes
  localparam logic [3:0] SPI_BITS   = 4'h8;
  localparam logic [3:0] NB_BASE    = 4'h5;
  localparam logic [3:0] NB_NINE    = 4'h9;
  localparam logic [9:0] HALF_MIN   = 10'h001;
  // high byte field positions
  localparam int HB_RXC  = 7;
  localparam int HB_OVF  = 6;
  localparam int HB_FRAME_ERROR_FLAG = 2;
  localparam int HB_PARITY_ERROR_FLAG = 1;
  localparam int HB_D8   = 0;

  typedef struct packed {
    logic [8:0] data;
    logic       frame_error_flag;
    logic       parity_error_flag;
    logic       ovf;
  } rx_entry_s;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_st_e;
endpackage : serial_rx_pkg

// File: core/rx_frame_if.sv
`timescale 1ns/1ps
interface rx_frame_if;
  import serial_rx_pkg::*;
  logic      push;
  rx_entry_s word;
  logic      shift;
  logic      flush;
  logic      err_off;
  rx_entry_s head;
  logic      head_valid;
  logic      full;
  modport src   (output push, word, shift, flush, err_off, input head, head_valid, full);
  modport store (input push, word, shift, flush, err_off, output head, head_valid, full);
endinterface : rx_frame_if

// File: core/sync_2ff.sv
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk_in, // destination clock
  input  wire logic [W-1:0] d_in,   // foreign level
  output logic      [W-1:0] q_out   // synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s r;
  sync_s n;

  // first stage feeds only the second
  always_comb begin
    n    = r;
    n.s1 = d_in;
    n.s2 = r.s1;
  end

  always_ff @(posedge clk_in) begin
    r <= n;
  end

  assign q_out = r.s2;
endmodule : sync_2ff

// File: core/rx_frame_store.sv
`timescale 1ns/1ps
module rx_frame_store
  import serial_rx_pkg::*;
(
  input  wire logic core_clk_in, // peripheral clock
  input  wire logic rst_in,      // synchronous reset
  input  wire logic clk_en_in,   // freezes state when low
  rx_frame_if.store fi           // frames in, oldest frame out
);
  typedef struct packed {
    rx_entry_s [1:0] e;
    logic [1:0]      v;
  } store_s;
  store_s r;
  store_s n;

  // shift first so a read frees room for a frame in the same cycle
  always_comb begin
    n = r;
    if (fi.shift && r.v[0]) begin
      n.e[0] = r.e[1];
      n.v[0] = r.v[1];
      n.e[1] = '0;
      n.v[1] = 1'b0;
    end
    if (fi.push) begin
      if (!n.v[0]) begin
        n.e[0] = fi.word;
        n.v[0] = 1'b1;
      end else if (!n.v[1]) begin
        n.e[1] = fi.word;
        n.v[1] = 1'b1;
      end else if (!fi.err_off) begin
        n.e[1].ovf = 1'b1;
      end
    end
    if (fi.flush) begin
      n = '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else if (clk_en_in) begin
      r <= n;
    end
  end

  assign fi.head       = r.e[0];
  assign fi.head_valid = r.v[0];
  assign fi.full       = r.v[1];

  a_ovf_mark: assert property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && fi.push && r.v[1] && !(fi.shift && r.v[0]) && !fi.err_off && !fi.flush
    |=> r.e[1].ovf && r.v[1]) else $error("overflow not recorded in held frame");
  c_overflow: cover property (@(posedge core_clk_in) disable iff (rst_in)
    clk_en_in && fi.push && r.v[1] && !fi.shift);
endmodule : rx_frame_store

// File: core/serial_rx_sync_core.sv
`timescale 1ns/1ps
module serial_rx_sync_core
  import serial_rx_pkg::*;
(
  input  wire logic        core_clk_in,            // peripheral clock
  input  wire logic        rst_in,                 // synchronous reset
  input  wire logic        clk_en_in,              // freezes state when low
  input  wire logic        tx_enable_in,           // software transmitter enable
  input  wire logic        tx_pending_in,          // tx path still holds data
  input  wire logic        rx_enable_in,           // software receiver enable
  input  wire logic [1:0]  comm_mode_in,           // async, sync or host spi
  input  wire logic [1:0]  rx_mode_in,             // async reception mode
  input  wire logic [2:0]  character_size_in,      // frame character size
  input  wire logic [1:0]  parity_mode_in,         // none, even, odd
  input  wire logic        bit_order_select_in,    // spi: 1 lsb first
  input  wire logic        clock_phase_select_in,  // spi clock phase
  input  wire logic        pin_invert_enable_in,   // transfer clock inversion
  input  wire logic        port_direction_in,      // transfer clock pin: 1 output
  input  wire logic [15:0] baud_in,                // baud setting
  input  wire logic        sample_tick_in,         // async oversample tick
  input  wire logic        rxd_in,                 // receive pin
  input  wire logic        xck_link_clk_in,        // client transfer clock
  input  wire logic        rd_low_in,              // read strobe, low byte
  input  wire logic        rd_high_in,             // read strobe, high byte
  output logic             tx_override_out,        // tx pin owned by block
  output logic             tx_dir_input_out,       // pulse: force tx pin input
  output logic             tx_shift_edge_out,      // host transmit edge pulse
  output logic             transfer_clock_pin_out, // transfer clock drive
  output logic             transfer_clock_oe_out,  // transfer clock enable
  output logic [7:0]       rx_data_low_out,        // oldest frame, low byte
  output logic [7:0]       rx_data_high_out,       // oldest frame, high byte
  output logic             receive_complete_flag_out // unread frame held
);
  typedef struct packed {
    logic       tx_on;
    logic       txdir;
    logic       txe;
    logic       hck;
    logic [9:0] hcnt;
    logic       xpin;
    logic       xoe;
    logic       crun;
    logic       tseen;
    rx_st_e     st;
    logic [4:0] os;
    logic [1:0] votes;
    logic [3:0] bidx;
    logic [8:0] sh;
    logic       par;
    logic       parity_error_flag;
  } core_s;

  typedef struct packed {
    logic bit_v;
    logic tog;
  } link_s;

  core_s      r;
  core_s      n;
  link_s      l;
  link_s      ln;
  logic       rxd_s;
  logic       tog_s;
  logic       lrun;
  logic       spi_c;
  logic       host_c;
  logic       lead_smp;
  logic       smp_c;
  logic       ev_c;
  logic       bv_c;
  logic       push_c;
  rx_entry_s  word_c;
  logic [4:0] os_c;
  logic [4:0] mid_c;
  logic [3:0] nb_c;
  logic [9:0] half_c;

  rx_frame_if fi ();

  rx_frame_store u_store (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .clk_en_in   (clk_en_in),
    .fi          (fi)
  );

  // pin and crossing synchronisers
  sync_2ff #(.W(1)) u_rxd (
    .clk_in (core_clk_in),
    .d_in   (rxd_in),
    .q_out  (rxd_s)
  );
  sync_2ff #(.W(1)) u_tog (
    .clk_in (core_clk_in),
    .d_in   (l.tog),
    .q_out  (tog_s)
  );
  sync_2ff #(.W(1)) u_run (
    .clk_in (xck_link_clk_in),
    .d_in   (r.crun),
    .q_out  (lrun)
  );

  // mode decode
  assign spi_c    = (comm_mode_in == MODE_SPI);
  assign host_c   = port_direction_in && comm_mode_in[0];
  assign lead_smp = spi_c && !clock_phase_select_in;
  assign os_c     = (rx_mode_in == RXM_DOUBLE) ? OS_DOUBLE : OS_NORMAL;
  assign mid_c    = os_c >> 1;
  assign nb_c     = character_size_in[2] ? NB_NINE : NB_BASE + {2'b00, character_size_in[1:0]};
  assign half_c   = (baud_in[15:6] == 10'h000) ? HALF_MIN : baud_in[15:6];

  // link side: sample on the falling edge of the client transfer clock, with no pin inversion applied
  always_comb begin
    ln = l;
    if (!lrun) begin
      ln = '0;
    end else begin
      ln.bit_v = rxd_in;
      ln.tog   = !l.tog;
    end
  end

  always_ff @(negedge xck_link_clk_in) begin
    l <= ln;
  end

  // core side state
  always_comb begin
    n      = r;
    push_c = 1'b0;
    word_c = '0;
    ev_c   = 1'b0;
    bv_c   = 1'b0;
    smp_c  = 1'b0;
    n.txe  = 1'b0;
    // deferred transmitter shutdown
    if (tx_enable_in) begin
      n.tx_on = 1'b1;
    end else if (!tx_pending_in) begin
      n.tx_on = 1'b0;
    end
    n.txdir = r.tx_on && !n.tx_on;
    // host clock: half period from integer baud part, stops at idle level
    n.xoe = host_c;
    if (host_c && (tx_pending_in || r.hck)) begin
      if (r.hcnt + 10'h001 >= half_c) begin
        n.hcnt = '0;
        n.hck  = !r.hck;
        smp_c  = (n.hck == lead_smp);
        n.txe  = !smp_c;
      end else begin
        n.hcnt = r.hcnt + 10'h001;
      end
    end else begin
      n.hcnt = '0;
      n.hck  = 1'b0;
    end
    n.xpin = n.hck ^ pin_invert_enable_in;
    // client crossing: one bit per toggle from the link side
    n.tseen = tog_s;
    n.crun  = rx_enable_in && !port_direction_in && (comm_mode_in == MODE_SYNC);
    // bit event sources
    if (!comm_mode_in[0]) begin
      if (sample_tick_in) begin
        if (r.st == RX_IDLE) begin
          if (!rxd_s) begin
            n.st    = RX_START;
            n.os    = OS_FIRST;
            n.votes = 2'b00;
          end
        end else begin
          n.os = (r.os == os_c) ? OS_FIRST : r.os + OS_FIRST;
          if (n.os >= mid_c && n.os <= mid_c + VOTE_SPAN) begin
            n.votes = r.votes + {1'b0, rxd_s};
          end
          if (n.os == mid_c + VOTE_SPAN) begin
            ev_c    = 1'b1;
            bv_c    = (n.votes >= 2'b10);
            n.votes = 2'b00;
          end
        end
      end
    end else if (port_direction_in) begin
      ev_c = smp_c;
      bv_c = rxd_s;
    end else begin
      ev_c = r.crun && (tog_s != r.tseen);
      bv_c = l.bit_v;
    end
    // framing of start, data, parity and first stop bit
    if (ev_c && !spi_c) begin
      unique case (r.st)
        RX_IDLE, RX_START: begin
          if (!bv_c) begin
            n.st   = RX_DATA;
            n.bidx = '0;
            n.sh   = '0;
            n.par  = 1'b0;
            n.parity_error_flag = 1'b0;
          end else begin
            n.st = RX_IDLE;
          end
        end
        RX_DATA: begin
          n.sh[r.bidx] = bv_c;
          n.par        = r.par ^ bv_c;
          if (r.bidx == nb_c - 4'h1) begin
            n.st = parity_mode_in[1] ? RX_PAR : RX_STOP;
          end else begin
            n.bidx = r.bidx + 4'h1;
          end
        end
        RX_PAR: begin
          n.parity_error_flag = (r.par ^ bv_c) != parity_mode_in[0];
          n.st   = RX_STOP;
        end
        RX_STOP: begin
          push_c      = 1'b1;
          word_c.data = r.sh;
          word_c.frame_error_flag = !bv_c;
          word_c.parity_error_flag = r.parity_error_flag;
          n.st        = RX_IDLE;
        end
        default: begin
          n.st = RX_IDLE;
        end
      endcase
    end
    // host spi: eight bits, no framing, flags stay zero
    if (ev_c && spi_c) begin
      if (bit_order_select_in) begin
        n.sh[r.bidx] = bv_c;
      end else begin
        n.sh = {1'b0, r.sh[6:0], bv_c};
      end
      if (r.bidx == SPI_BITS - 4'h1) begin
        push_c      = 1'b1;
        word_c.data = {1'b0, n.sh[7:0]};
        n.bidx      = '0;
        n.sh        = '0;
      end else begin
        n.bidx = r.bidx + 4'h1;
      end
    end
    // receiver disable drops the frame in progress
    if (!rx_enable_in) begin
      n.st    = RX_IDLE;
      n.bidx  = '0;
      n.sh    = '0;
      n.votes = 2'b00;
      push_c  = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else if (clk_en_in) begin
      r <= n;
    end
  end

  // buffer control
  assign fi.push    = push_c;
  assign fi.word    = word_c;
  assign fi.flush   = !rx_enable_in;
  assign fi.err_off = spi_c;
  assign fi.shift   = (character_size_in == CS_9L) ? rd_high_in : rd_low_in;

  // outputs
  assign tx_override_out           = r.tx_on;
  assign tx_dir_input_out          = r.txdir;
  assign tx_shift_edge_out         = r.txe;
  assign transfer_clock_pin_out    = r.xpin;
  assign transfer_clock_oe_out     = r.xoe;
  assign receive_complete_flag_out = fi.head_valid;
  assign rx_data_low_out           = fi.head.data[7:0];
  assign rx_data_high_out          = {fi.head_valid, fi.head.ovf, 3'b000,
                                      fi.head.frame_error_flag, fi.head.parity_error_flag, fi.head.data[8]};

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_tx_hold: assert property (clk_en_in && tx_override_out && tx_pending_in |=> tx_override_out)
    else $error("transmitter released with data pending");
  a_tx_release: assert property ($fell(tx_override_out) |-> tx_dir_input_out && $past(!tx_pending_in))
    else $error("pin not returned on disable");
  a_flush_now: assert property (clk_en_in && !rx_enable_in |=> !receive_complete_flag_out)
    else $error("buffer not flushed on disable");
  a_push_flag: assert property (clk_en_in && rx_enable_in && push_c |=> receive_complete_flag_out)
    else $error("receive complete not set");
  a_read_shift: assert property (clk_en_in && rx_enable_in && receive_complete_flag_out && !fi.full
    && !push_c && character_size_in != CS_9L && rd_low_in |=> !receive_complete_flag_out)
    else $error("low byte read did not advance");
  a_read_hold_9l: assert property (clk_en_in && rx_enable_in && receive_complete_flag_out
    && character_size_in == CS_9L && rd_low_in && !rd_high_in |=> receive_complete_flag_out)
    else $error("low byte read advanced in nine bit low first");
  a_client_no_clk: assert property (!port_direction_in [*2] |-> !transfer_clock_oe_out)
    else $error("client drives transfer clock");
  a_spi_edge: assert property (tx_shift_edge_out && spi_c && !clock_phase_select_in
    && $stable(pin_invert_enable_in) |-> transfer_clock_pin_out == pin_invert_enable_in)
    else $error("spi transmit edge not trailing");
  a_spi_no_err: assert property (push_c && spi_c |-> !word_c.frame_error_flag && !word_c.parity_error_flag && word_c.data[8] == 1'b0)
    else $error("spi frame carries error flags");
  a_stop_frame_error_flag: assert property (clk_en_in && rx_enable_in && ev_c && !spi_c && r.st == RX_STOP
    && !receive_complete_flag_out |=> rx_data_high_out[HB_FRAME_ERROR_FLAG] == $past(!bv_c))
    else $error("frame error mismatch");

  c_tx_release: cover property ($fell(tx_override_out));
  c_spi_frame: cover property (push_c && spi_c);
  c_two_frames: cover property (fi.full && receive_complete_flag_out);
endmodule : serial_rx_sync_core

// File: verification/serial_line_model.sv
`timescale 1ns/1ps
module serial_line_model (
  input  wire logic core_clk_in,  // peripheral clock
  input  wire logic xck_pin_in,   // host transfer clock pin
  output logic      rxd_out,      // line towards the receiver
  output logic      link_clk_out  // client transfer clock
);
  logic       spi_on;   // spi client answering
  logic       cpha;     // clock phase in use
  logic       inv;      // pin inversion in use
  logic       lsb;      // lsb first
  logic [7:0] spi_byte; // byte sent every frame
  int         idx;      // next bit index

  // line idles high, clock stands still
  initial begin
    rxd_out = 1'b1;
    link_clk_out = 1'b0;
    spi_on = 1'b0;
  end

  // async frame, lsb first, os core cycles per bit
  task automatic send_async(input logic [11:0] bits, input int n, input int os);
    for (int i = 0; i < n; i++) begin
      rxd_out = bits[i];
      repeat (os) @(posedge core_clk_in);
      #1;
    end
    rxd_out = 1'b1;
  endtask : send_async

  // client frame: data changes on rising, 168 ns period keeps below a quarter of the core clock
  task automatic send_sync(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      link_clk_out = 1'b1;
      rxd_out = bits[i];
      #84 link_clk_out = 1'b0;
      #84;
    end
    rxd_out = 1'b1;
  endtask : send_sync

  // arm the spi client with its byte and edge roles
  task automatic spi_load(input logic [7:0] b, input logic ph, input logic iv, input logic lf);
    spi_byte = b;
    cpha = ph;
    inv = iv;
    lsb = lf;
    idx = ph ? 0 : 1;
    rxd_out = lf ? b[0] : b[7];
    spi_on = 1'b1;
  endtask : spi_load

  // release the data line
  task automatic spi_off();
    spi_on = 1'b0;
    rxd_out = 1'b1;
  endtask : spi_off

  // next bit on the transmit edge of the pin
  always @(xck_pin_in) begin
    if (spi_on && xck_pin_in === (cpha ^ inv)) begin
      rxd_out = lsb ? spi_byte[idx % 8] : spi_byte[7 - idx % 8];
      idx = idx + 1;
    end
  end
endmodule : serial_line_model

// File: verification/serial_rx_sync_core_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end \
end
module serial_rx_sync_core_tb
  import serial_rx_pkg::*;
;
  logic        core_clk_in, rst_in, tx_enable, tx_pending, rx_enable;
  logic [1:0]  comm_mode, rx_mode, parity_mode;
  logic [2:0]  char_size;
  logic        order, cpha, inv, port_dir, rd_low, rd_high;
  logic [15:0] baud;
  logic        rxd, link_clk, tx_ovr, tx_dir, xck_pin, xck_oe, rx_flag, clk_en, tx_edge;
  logic [7:0]  rx_lo, rx_hi;
  int          num_errors = 0;
  int          compares = 0;
  int          edge_cnt = 0;

  serial_rx_sync_core u_serial_rx_sync_core (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
    .tx_enable_in(tx_enable), .tx_pending_in(tx_pending), .rx_enable_in(rx_enable),
    .comm_mode_in(comm_mode), .rx_mode_in(rx_mode), .character_size_in(char_size),
    .parity_mode_in(parity_mode), .bit_order_select_in(order), .clock_phase_select_in(cpha),
    .pin_invert_enable_in(inv), .port_direction_in(port_dir), .baud_in(baud),
    .sample_tick_in(1'b1), .rxd_in(rxd), .xck_link_clk_in(link_clk),
    .rd_low_in(rd_low), .rd_high_in(rd_high), .tx_override_out(tx_ovr),
    .tx_dir_input_out(tx_dir), .tx_shift_edge_out(tx_edge), .transfer_clock_pin_out(xck_pin),
    .transfer_clock_oe_out(xck_oe), .rx_data_low_out(rx_lo), .rx_data_high_out(rx_hi),
    .receive_complete_flag_out(rx_flag));

  serial_line_model u_serial_line_model (
    .core_clk_in(core_clk_in), .xck_pin_in(xck_pin), .rxd_out(rxd), .link_clk_out(link_clk));

  // 25 MHz core clock
  always #20 core_clk_in = ~core_clk_in;

  // count host transmit edge pulses mid-cycle, where they stand settled
  always @(negedge core_clk_in) begin
    if (tx_edge === 1'b1) edge_cnt++;
  end

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic step(input int n = 1);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step

  // bounded wait for the receive flag level
  task automatic wait_flag(input logic lvl);
    int k;
    k = 0;
    while (rx_flag !== lvl && k < 3000) begin
      step();
      k++;
    end
    if (rx_flag !== lvl) begin
      num_errors++;
      $display("[FAIL] flag wait expected %h seen %h", lvl, rx_flag);
      test_done();
    end
  endtask : wait_flag

  // one-cycle read strobe, high or low byte
  task automatic rd(input logic hi);
    if (hi) rd_high = 1'b1;
    else rd_low = 1'b1;
    step();
    rd_high = 1'b0;
    rd_low = 1'b0;
    step();
  endtask : rd

  task automatic chk(input logic [7:0] lo, input logic [7:0] hi);
    `CHK("data low", lo, rx_lo)
    `CHK("data high", hi, rx_hi)
  endtask : chk

  // await one frame, check it, read it out the usual way
  task automatic take(input logic [7:0] lo, input logic [7:0] hi);
    wait_flag(1'b1);
    chk(lo, hi);
    rd(1'b1);
    rd(1'b0);
    `CHK("flag after read", 1'b0, rx_flag)
  endtask : take

  // par: 0 none, 1 even, 2 odd, 3 wrong even; os 0 sends on the client clock
  task automatic send(input logic [8:0] d, input int nb, input int par, input logic stp, input int os);
    logic [11:0] f;
    logic        p;
    int          n;
    f = 12'h000;
    for (int i = 0; i < nb; i++) f[i+1] = d[i];
    p = ^(d & ((9'h001 << nb) - 9'h001));
    n = nb + 1;
    if (par != 0) begin
      f[n] = p ^ (par != 1);
      n++;
    end
    f[n] = stp;
    n++;
    if (os == 0) u_serial_line_model.send_sync(f, n);
    else u_serial_line_model.send_async(f, n, os);
    step();
  endtask : send

  task automatic t_tx_disable();
    tx_enable = 1'b1;
    tx_pending = 1'b1;
    step(2);
    tx_enable = 1'b0;
    step(3);
    `CHK("override while pending", 1'b1, tx_ovr)
    tx_pending = 1'b0;
    step();
    `CHK("override dropped", 1'b0, tx_ovr)
    `CHK("direction pulse", 1'b1, tx_dir)
    step();
    `CHK("direction pulse end", 1'b0, tx_dir)
  endtask : t_tx_disable

  task automatic t_async();
    parity_mode = PAR_EVEN;
    send(9'h0a5, 8, 1, 1'b1, 16);
    take(8'ha5, 8'h80);
    send(9'h03c, 8, 3, 1'b1, 16);
    take(8'h3c, 8'h82);
    send(9'h00f, 8, 1, 1'b0, 16);
    take(8'h0f, 8'h84);
  endtask : t_async

  task automatic t_overflow();
    parity_mode = 2'h0;
    send(9'h011, 8, 0, 1'b1, 16);
    send(9'h022, 8, 0, 1'b1, 16);
    send(9'h033, 8, 0, 1'b1, 16);
    step(4);
    chk(8'h11, 8'h80);
    rd(1'b0);
    chk(8'h22, 8'hc0);
    rd(1'b0);
    `CHK("flag after drain", 1'b0, rx_flag)
  endtask : t_overflow

  // a frozen core ignores a read strobe, then resumes where it stood
  task automatic t_freeze();
    send(9'h066, 8, 0, 1'b1, 16);
    wait_flag(1'b1);
    clk_en = 1'b0;
    rd(1'b0);
    `CHK("frozen read", 1'b1, rx_flag)
    clk_en = 1'b1;
    take(8'h66, 8'h80);
  endtask : t_freeze

  task automatic t_nine();
    char_size = CS_9L;
    rx_mode = RXM_DOUBLE;
    send(9'h1a5, 9, 0, 1'b1, 8);
    send(9'h05a, 9, 0, 1'b1, 8);
    step(4);
    chk(8'ha5, 8'h81);
    rd(1'b0);
    chk(8'ha5, 8'h81);
    rd(1'b1);
    chk(8'h5a, 8'h80);
    rd(1'b1);
    `CHK("flag nine bit", 1'b0, rx_flag)
    char_size = 3'h3;
    rx_mode = 2'h0;
  endtask : t_nine

  task automatic t_disable();
    send(9'h077, 8, 0, 1'b1, 16);
    wait_flag(1'b1);
    rx_enable = 1'b0;
    step();
    `CHK("flush on disable", 1'b0, rx_flag)
    rx_enable = 1'b1;
    fork
      send(9'h0ff, 8, 0, 1'b1, 16);
      begin
        step(60);
        rx_enable = 1'b0;
        step();
        rx_enable = 1'b1;
      end
    join
    step(40);
    `CHK("frame dropped", 1'b0, rx_flag)
  endtask : t_disable

  task automatic t_spi();
    logic [7:0] b;
    comm_mode = MODE_SPI;
    port_dir = 1'b1;
    // half period of four core cycles leaves room for the pin synchroniser
    baud = 16'h0100;
    parity_mode = PAR_EVEN;
    for (int k = 0; k < 4; k++) begin
      cpha = k[0];
      inv = k[1];
      order = k[0] ^ k[1];
      b = 8'hc5 ^ 8'(k);
      step(3);
      `CHK("host clock enable", 1'b1, xck_oe)
      `CHK("clock idle level", inv, xck_pin)
      u_serial_line_model.spi_load(b, cpha, inv, order);
      edge_cnt = 0;
      tx_pending = 1'b1;
      wait_flag(1'b1);
      tx_pending = 1'b0;
      chk(b, 8'h80);
      rx_enable = 1'b0;
      step(8);
      `CHK("transmit edges", 8, edge_cnt)
      u_serial_line_model.spi_off();
      rx_enable = 1'b1;
    end
    inv = 1'b0;
    cpha = 1'b0;
  endtask : t_spi

  task automatic t_client();
    // link side has no reset: idle clocks with run low clear it
    u_serial_line_model.send_sync(12'hfff, 3);
    step();
    comm_mode = MODE_SYNC;
    port_dir = 1'b0;
    step(3);
    `CHK("client clock released", 1'b0, xck_oe)
    // idle clocks carry the run level across before the first start bit
    u_serial_line_model.send_sync(12'hfff, 3);
    step();
    send(9'h05e, 8, 1, 1'b1, 0);
    take(8'h5e, 8'h80);
    parity_mode = PAR_ODD;
    send(9'h0c3, 8, 2, 1'b1, 0);
    take(8'hc3, 8'h80);
  endtask : t_client

  initial begin
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    tx_enable = 1'b0;
    tx_pending = 1'b0;
    rx_enable = 1'b0;
    comm_mode = MODE_ASYNC;
    rx_mode = 2'h0;
    parity_mode = 2'h0;
    char_size = 3'h3;
    {order, cpha, inv, port_dir, rd_low, rd_high} = 6'h00;
    clk_en = 1'b1;
    baud = 16'h0040;
    step(6);
    rst_in = 1'b0;
    rx_enable = 1'b1;
    t_tx_disable();
    t_async();
    t_overflow();
    t_freeze();
    t_nine();
    t_disable();
    t_spi();
    t_client();
    test_done();
  end
endmodule : serial_rx_sync_core_tb
